// ---- bench/bbp_pins.sv ----
// board model for the port pins: pull-ups, external drivers, floating lines
// assumes one pclk domain; the testbench chooses which inputs an external driver holds
`timescale 1ns/100ps
`default_nettype none
module bbp_pins (
  input wire logic pclk,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pullup_on,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_in
);
  // an undriven line must not look stable, so it toggles every cycle
  logic [7:0] float_q = 8'h55;
  always_ff @(posedge pclk) begin
    float_q <= ~float_q;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : pullup_on[i] ? 1'b1 : float_q[i];
    end
  end
endmodule
`default_nettype wire

// ---- bench/bbp_port_checker.sv ----
// assertions on the port block, bound to its ports
// assumes one clock, pclk, and async active-low presetn
`timescale 1ns/100ps
`default_nettype none
module bbp_port_checker #(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [WIDTH-1:0] pin_in,
  input wire logic [WIDTH-1:0] pin_out,
  input wire logic [WIDTH-1:0] pin_oe,
  input wire logic [WIDTH-1:0] pullup_on,
  input wire logic prog_clk,
  input wire logic prog_data,
  input wire logic irq
);
  logic wr;
  logic dir_wr;
  assign wr = psel && penable && pwrite && clk_en;
  assign dir_wr = wr && paddr == bbp_pkg::OFS_DIRECTION;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_oe; dir_wr |=> pin_oe == ~$past(pwdata[WIDTH-1:0]); endproperty
  a_oe: assert property (p_oe) else $error("drive enables do not follow direction write");
  property p_hold; !$past(dir_wr) |-> $stable(pin_oe); endproperty
  a_hold: assert property (p_hold) else $error("drive enables moved without direction write");
  property p_lat; wr && paddr == bbp_pkg::OFS_PIN_DATA |=> pin_out == $past(pwdata[WIDTH-1:0]); endproperty
  a_lat: assert property (p_lat) else $error("latch not loaded by data write");
  property p_bit; wr && paddr == bbp_pkg::OFS_BIT_OP |=> pin_out[$past(pwdata[2:0])] == $past(pwdata[3]); endproperty
  a_bit: assert property (p_bit) else $error("bit operation lost its bit");
  property p_pu_out; (pullup_on & pin_oe) == '0; endproperty
  a_pu_out: assert property (p_pu_out) else $error("pull-up left on an output");
  property p_pu_off; wr && paddr == bbp_pkg::OFS_OPTION && pwdata[7] |=> pullup_on == '0; endproperty
  a_pu_off: assert property (p_pu_off) else $error("pull-ups not off");
  property p_pu_on; wr && paddr == bbp_pkg::OFS_OPTION && !pwdata[7] |=> pullup_on == ~pin_oe; endproperty
  a_pu_on: assert property (p_pu_on) else $error("pull-ups not on for inputs");
  property p_prog; wr && paddr == bbp_pkg::OFS_MODE && !pwdata[1] |=> !prog_clk && !prog_data; endproperty
  a_prog: assert property (p_prog) else $error("programming lines active outside the mode");
  property p_irq; wr && paddr == bbp_pkg::OFS_IRQ_ENABLE && pwdata[1:0] == 2'h0 |=> !irq; endproperty
  a_irq: assert property (p_irq) else $error("interrupt high while masked");
  property p_err; psel && penable && !(paddr inside {12'h018, 12'h204, 12'h218, [12'h240:12'h250]}) |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
endmodule
bind bbp_port bbp_port_checker #(.WIDTH(WIDTH)) bbp_port_checker_inst (.pclk(pclk), .presetn(presetn),
  .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
  .pullup_on(pullup_on), .prog_clk(prog_clk), .prog_data(prog_data), .irq(irq));
`default_nettype wire

// ---- bench/bbp_port_tb.sv ----
// testbench for the port block: apb tasks, board model, directed sequence
// assumes zero-wait apb slave and pins synchronised by two flops
`timescale 1ns/100ps
`default_nettype none
module bbp_port_tb;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, prog_clk, prog_data, irq, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [7:0] pin_in, pin_out, pin_oe, pullup_on, ext_en, ext_val;
  int num_errors = 0;
  int total_checks = 0;
  bbp_port #(.WIDTH(8)) bbp_port_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on),
    .prog_clk(prog_clk), .prog_data(prog_data), .irq(irq));
  bbp_pins bbp_pins_inst (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on),
    .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // one transfer; read data and error are taken at the pready edge only
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  // new external levels, then time for synchroniser and filter
  task automatic pins(input logic [7:0] en, input logic [7:0] val);
    @(posedge pclk);
    ext_en <= en;
    ext_val <= val;
    idle(4);
  endtask
  initial begin
    #100000;
    num_errors++;
    final_report();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, ext_en, ext_val} = '0;
    clk_en = 1'b1;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    idle(1);
    chk(pin_oe, 0);
    chk(pullup_on, 0);
    apb(0, bbp_pkg::OFS_OPTION, 0);
    chk(rdat, 32'hFF);
    apb(0, bbp_pkg::OFS_DIRECTION, 0);
    chk(rdat, 32'hFF);
    apb(1, bbp_pkg::OFS_OPTION, 32'h7F);
    idle(1);
    chk(pullup_on, 8'hFF);
    apb(1, bbp_pkg::OFS_DIRECTION, 32'hCF);
    idle(1);
    chk(pin_oe, 8'h30);
    chk(pullup_on, 8'hCF);
    pins(8'h0F, 8'h04);
    apb(1, bbp_pkg::OFS_PIN_DATA, 32'h00);
    idle(3);
    apb(0, bbp_pkg::OFS_PIN_DATA, 0);
    chk(rdat, 32'hC4);
    apb(1, bbp_pkg::OFS_BIT_OP, 32'h0D);
    idle(1);
    chk(pin_out, 8'hE4);
    apb(1, bbp_pkg::OFS_IRQ_CLEAR, 32'h03);
    apb(1, bbp_pkg::OFS_IRQ_ENABLE, 32'h02);
    pins(8'h0F, 8'h0C);
    apb(0, bbp_pkg::OFS_IRQ_STATUS, 0);
    chk(rdat, 0);
    pins(8'h4F, 8'h0C);
    apb(0, bbp_pkg::OFS_IRQ_STATUS, 0);
    chk(rdat, 32'h02);
    chk(irq, 1);
    apb(1, bbp_pkg::OFS_IRQ_ENABLE, 0);
    idle(1);
    chk(irq, 0);
    apb(1, bbp_pkg::OFS_IRQ_ENABLE, 32'h02);
    apb(0, bbp_pkg::OFS_PIN_DATA, 0);
    chk(rdat, 32'hAC);
    apb(1, bbp_pkg::OFS_IRQ_CLEAR, 32'h02);
    apb(0, bbp_pkg::OFS_IRQ_STATUS, 0);
    chk(rdat, 0);
    chk(irq, 0);
    apb(1, bbp_pkg::OFS_MODE, 32'h01);
    apb(1, bbp_pkg::OFS_IRQ_CLEAR, 32'h03);
    pins(8'h4F, 8'h0D);
    apb(0, bbp_pkg::OFS_IRQ_STATUS, 0);
    chk(rdat, 32'h01);
    apb(1, bbp_pkg::OFS_MODE, 32'h02);
    pins(8'h4F, 8'h4D);
    chk(prog_clk, 1);
    chk(prog_data, 1);
    apb(0, 12'h100, 0);
    chk(rerr, 1);
    chk(rdat, 0);
    apb(1, bbp_pkg::OFS_OPTION, 32'hFF);
    idle(1);
    chk(pullup_on, 0);
    // frozen clock enable: the write must not land
    @(posedge pclk);
    clk_en <= 1'b0;
    apb(1, bbp_pkg::OFS_OPTION, 32'h7F);
    @(posedge pclk);
    clk_en <= 1'b1;
    apb(0, bbp_pkg::OFS_OPTION, 0);
    chk(rdat, 32'hFF);
    chk(pullup_on, 0);
    final_report();
  end
endmodule
`default_nettype wire

// ---- hw/bbp_pkg.sv ----
// package for the eight-bit bidirectional port: offsets, reset values, field positions
// assumes an apb slave with 32-bit data, one register per aligned word
package bbp_pkg;
  // ----------------------------------------------------------------
  // register byte addresses (index times four)
  // ----------------------------------------------------------------
  localparam logic [11:0] IDX_PIN_DATA = 12'h006;
  localparam logic [11:0] IDX_OPTION = 12'h081;
  localparam logic [11:0] IDX_DIRECTION = 12'h086;
  localparam logic [11:0] IDX_BIT_OP = 12'h090;
  localparam logic [11:0] IDX_MODE = 12'h091;
  localparam logic [11:0] IDX_IRQ_STATUS = 12'h092;
  localparam logic [11:0] IDX_IRQ_CLEAR = 12'h093;
  localparam logic [11:0] IDX_IRQ_ENABLE = 12'h094;
  localparam logic [11:0] OFS_PIN_DATA = 12'h018;
  localparam logic [11:0] OFS_OPTION = 12'h204;
  localparam logic [11:0] OFS_DIRECTION = 12'h218;
  localparam logic [11:0] OFS_BIT_OP = 12'h240;
  localparam logic [11:0] OFS_MODE = 12'h244;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h248;
  localparam logic [11:0] OFS_IRQ_CLEAR = 12'h24C;
  localparam logic [11:0] OFS_IRQ_ENABLE = 12'h250;
  // ----------------------------------------------------------------
  // reset values and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_OPTION = 8'hFF;
  localparam logic [7:0] RST_DIRECTION = 8'hFF;
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam int POS_PULLUP_EN_N = 7;
  localparam int POS_EDGE_SEL = 6;
  localparam int POS_MODE_EXT_IRQ = 0;
  localparam int POS_MODE_PROG = 1;
  localparam int POS_OP_SET = 3;
  localparam int POS_OP_BIT = 0;
  localparam int POS_EV_EXT = 0;
  localparam int POS_EV_CHANGE = 1;
  localparam logic [3:0] CHANGE_MASK_HI = 4'hF;
endpackage

// ---- hw/bbp_port.sv ----
// eight-bit bidirectional port with pull-ups, change detect and external irq pin
// assumes apb master on pclk; pins arrive asynchronously and pass a two-flop synchroniser
`timescale 1ns/100ps
`default_nettype none
module bbp_port #(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe,
  output logic [WIDTH-1:0] pullup_on,
  output logic prog_clk,
  output logic prog_data,
  output logic irq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] pin_sync;
  logic [7:0] latch_q;
  logic [7:0] direction_reg_q;
  logic [7:0] option_q;
  logic [1:0] mode_q;
  logic [7:0] pin_data_reg;
  logic [7:0] sample_q;
  logic [3:0] last_read_q;
  logic [1:0] irq_status_q;
  logic [1:0] irq_enable_q;
  logic [2:0] hyst_q;
  logic ext_irq_pin_d1_q;
  logic pin_change_flag;
  logic pullup_enable_n;
  logic setup;
  logic access;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic [7:0] rmw_value;
  logic ext_irq_pin;
  logic ext_edge;
  logic [3:0] mismatch;

  bbp_sync #(.WIDTH(WIDTH)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .async_in(pin_in),
    .sync_out(pin_sync)
  );

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // setup cycle takes the pin sample, access cycle commits: two-phase like the core's instruction cycle
  assign setup = psel && !penable && clk_en;
  assign access = psel && penable && clk_en;
  assign wr_en = access && pwrite && mapped;
  assign rd_en = access && !pwrite && mapped;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_comb begin
    case (paddr)
      bbp_pkg::OFS_PIN_DATA, bbp_pkg::OFS_OPTION, bbp_pkg::OFS_DIRECTION, bbp_pkg::OFS_BIT_OP,
      bbp_pkg::OFS_MODE, bbp_pkg::OFS_IRQ_STATUS, bbp_pkg::OFS_IRQ_CLEAR,
      bbp_pkg::OFS_IRQ_ENABLE: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // pin input path
  // ----------------------------------------------------------------
  // hysteresis is modelled as a one-cycle delay: the previous synchronised sample wins whenever the new one differs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hyst_q <= 3'h0;
    end else if (clk_en) begin
      hyst_q <= {pin_sync[7], pin_sync[6], pin_sync[0]};
    end
  end

  function automatic logic maj(input logic a, input logic b);
    maj = (a == b) ? a : !a;
    return (a & b) | (a & maj) | (b & maj);
  endfunction

  always_comb begin
    pin_data_reg = pin_sync;
    if (mode_q[bbp_pkg::POS_MODE_EXT_IRQ]) begin
      pin_data_reg[0] = (hyst_q[0] == pin_sync[0]) ? pin_sync[0] : hyst_q[0];
    end
    if (mode_q[bbp_pkg::POS_MODE_PROG]) begin
      pin_data_reg[6] = (hyst_q[1] == pin_sync[6]) ? pin_sync[6] : hyst_q[1];
      pin_data_reg[7] = (hyst_q[2] == pin_sync[7]) ? pin_sync[7] : hyst_q[2];
    end
  end

  assign prog_clk = mode_q[bbp_pkg::POS_MODE_PROG] & pin_data_reg[6];
  assign prog_data = mode_q[bbp_pkg::POS_MODE_PROG] & pin_data_reg[7];

  // ----------------------------------------------------------------
  // pin samples at start of access
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_q <= 8'h00;
    end else if (setup) begin
      sample_q <= pin_data_reg;
    end
  end

  // bit op register: bit index in [2:0], set/clear in [3]
  always_comb begin
    rmw_value = sample_q;
    rmw_value[pwdata[2:0]] = pwdata[bbp_pkg::POS_OP_SET];
  end

  // ----------------------------------------------------------------
  // latch, direction, option, mode
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_q <= bbp_pkg::RST_LATCH;
    end else if (wr_en && paddr == bbp_pkg::OFS_PIN_DATA) begin
      latch_q <= pwdata[7:0];
    end else if (wr_en && paddr == bbp_pkg::OFS_BIT_OP) begin
      latch_q <= rmw_value;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      direction_reg_q <= bbp_pkg::RST_DIRECTION;
    end else if (wr_en && paddr == bbp_pkg::OFS_DIRECTION) begin
      direction_reg_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      option_q <= bbp_pkg::RST_OPTION;
    end else if (wr_en && paddr == bbp_pkg::OFS_OPTION) begin
      option_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 2'h0;
    end else if (wr_en && paddr == bbp_pkg::OFS_MODE) begin
      mode_q <= pwdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // pin drivers and pull-ups
  // ----------------------------------------------------------------
  assign pullup_enable_n = option_q[bbp_pkg::POS_PULLUP_EN_N];
  assign pin_out = latch_q;
  assign pin_oe = ~direction_reg_q;
  assign pullup_on = {WIDTH{!pullup_enable_n}} & direction_reg_q;

  // ----------------------------------------------------------------
  // change detection and external interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_read_q <= 4'h0;
    end else if (access && paddr == bbp_pkg::OFS_PIN_DATA) begin
      // a write also ends the mismatch, since it rereads the pins
      last_read_q <= sample_q[7:4];
    end
  end

  assign mismatch = (pin_data_reg[7:4] ^ last_read_q) & direction_reg_q[7:4] & bbp_pkg::CHANGE_MASK_HI;
  assign pin_change_flag = |mismatch;

  assign ext_irq_pin = pin_data_reg[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_irq_pin_d1_q <= 1'b0;
    end else if (clk_en) begin
      ext_irq_pin_d1_q <= ext_irq_pin;
    end
  end

  // edge select: one selects rising, zero falling
  assign ext_edge = mode_q[bbp_pkg::POS_MODE_EXT_IRQ] &&
                    (option_q[bbp_pkg::POS_EDGE_SEL] ? (ext_irq_pin && !ext_irq_pin_d1_q)
                                                    : (!ext_irq_pin && ext_irq_pin_d1_q));

  // ----------------------------------------------------------------
  // interrupt status, clear, enable
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= 2'h0;
    end else if (clk_en) begin
      // set beats clear; a lasting mismatch re-sets the change bit each cycle
      irq_status_q[bbp_pkg::POS_EV_EXT] <= ext_edge ||
        (irq_status_q[bbp_pkg::POS_EV_EXT] &&
         !(wr_en && paddr == bbp_pkg::OFS_IRQ_CLEAR && pwdata[bbp_pkg::POS_EV_EXT]));
      irq_status_q[bbp_pkg::POS_EV_CHANGE] <= pin_change_flag ||
        (irq_status_q[bbp_pkg::POS_EV_CHANGE] &&
         !(wr_en && paddr == bbp_pkg::OFS_IRQ_CLEAR && pwdata[bbp_pkg::POS_EV_CHANGE]));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable_q <= 2'h0;
    end else if (wr_en && paddr == bbp_pkg::OFS_IRQ_ENABLE) begin
      irq_enable_q <= pwdata[1:0];
    end
  end

  assign irq = |(irq_status_q & irq_enable_q);

  // ----------------------------------------------------------------
  // read data, registered at the setup edge
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      case (paddr)
        bbp_pkg::OFS_PIN_DATA: prdata <= {24'h000000, pin_data_reg};
        bbp_pkg::OFS_OPTION: prdata <= {24'h000000, option_q};
        bbp_pkg::OFS_DIRECTION: prdata <= {24'h000000, direction_reg_q};
        bbp_pkg::OFS_MODE: prdata <= {30'h00000000, mode_q};
        bbp_pkg::OFS_IRQ_STATUS: prdata <= {30'h00000000, irq_status_q};
        bbp_pkg::OFS_IRQ_ENABLE: prdata <= {30'h00000000, irq_enable_q};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- hw/bbp_sync.sv ----
// two-flop synchroniser for a pin bus
// assumes pins are asynchronous to pclk
`timescale 1ns/100ps
`default_nettype none
module bbp_sync #(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1_q <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      stage1_q <= async_in;
      sync_out <= stage1_q;
    end
  end
endmodule
`default_nettype wire
